// ===== dv/reset_gen_model.sv
// Purpose: board side of the reset pin, pull-up plus outside generator
// Assumes: device pulls the pin only through its open-drain output
// Notes: hold_low_i lets the bench stretch the sequence on purpose
`timescale 1ns/1ps

module reset_gen_model (
  input wire logic dev_out_i,
  input wire logic dev_oe_n_i,
  input wire logic hold_low_i,
  output logic pin_n_o
);
  // ****************************************
  // wired pin level
  // ****************************************
  // pull-up wins only when nobody pulls low; a device driving high shows
  // up as high here and is caught by the bench monitor
  assign pin_n_o = ((!dev_oe_n_i && !dev_out_i) || hold_low_i) ? 1'b0 :
                   1'b1;
endmodule : reset_gen_model

// ===== dv/reset_sequence_timing_tb_top.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: shortened cycle counts, outside generator model on the pin
// Notes: lengths are checked in a small window from the nominal count up to a few cycles above it
`timescale 1ns/1ps

module reset_sequence_timing_tb_top;
  import rst_seq_pkg::*;
  localparam int DS = 90;
  localparam int DP = 40;
  localparam int EL = 80;
  localparam int FL = 30;
  localparam int FS = 20;
  localparam int BF = 50;
  localparam int BL = 70;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  cause_e cause_i = CAUSE_NONE;
  logic selftest_en_i = 1'b0;
  logic header_last_i = 1'b0;
  logic ext_hold = 1'b0;
  logic pin_n;
  logic pin_out;
  logic pin_oe_n;
  seq_status_s status_o;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h4623_3f13;

  initial forever #12.5 mclk_i = ~mclk_i;

  reset_sequence_timing #(
    .DSELF_CYCLES(DS), .DPLAIN_CYCLES(DP), .EXTLONG_CYCLES(EL),
    .FLONG_CYCLES(FL), .FSHORT_CYCLES(FS), .BOOT_FIRST_CYCLES(BF),
    .BOOT_LAST_CYCLES(BL)
  ) i_reset_sequence_timing (
    .mclk_i(mclk_i), .rst_i(rst_i), .cause_i(cause_i),
    .selftest_en_i(selftest_en_i), .header_last_i(header_last_i),
    .reset_pin_n_i(pin_n), .reset_pin_n_o(pin_out),
    .reset_pin_n_oe_n_o(pin_oe_n), .status_o(status_o)
  );

  reset_gen_model i_reset_gen_model (
    .dev_out_i(pin_out), .dev_oe_n_i(pin_oe_n), .hold_low_i(ext_hold),
    .pin_n_o(pin_n)
  );

  // ****************************************
  // checking helpers
  // ****************************************
  function automatic int exp_len(cause_e c, logic st);
    case (c)
      CAUSE_DESTRUCTIVE: return st ? DS : DP;
      CAUSE_EXT_LONG: return EL;
      CAUSE_FUNC_LONG: return FL;
      CAUSE_FUNC_SHORT: return FS;
      default: return DP;
    endcase
  endfunction : exp_len

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  always @(negedge mclk_i) begin
    if (!rst_i && pin_oe_n === 1'b0) begin
      check("pin_drive_low", pin_out, 1'b0);
    end
  end

  // ****************************************
  // one whole sequence, cause to first fetch
  // ****************************************
  // CAUSE_NONE means the sequence started by leaving reset
  task automatic run_seq(cause_e c, logic st, logic hl, int hold);
    int n;
    int lo;
    int hi;
    n = 0;
    if (c != CAUSE_NONE) begin
      cause_i = c;
      selftest_en_i = st;
      header_last_i = hl;
      @(negedge mclk_i);
      cause_i = CAUSE_NONE;
      // later changes must not matter, they are taken with the cause
      selftest_en_i = 1'($random(seed));
      header_last_i = 1'($random(seed));
    end
    check("pin_low", pin_n, 1'b0);
    ext_hold = (hold > 0);
    lo = exp_len(c, st);
    while (pin_oe_n !== 1'b1 && n < 20000) begin
      @(negedge mclk_i);
      n++;
    end
    check("reset_len", (n >= lo && n <= lo + 2), 1);
    check("in_reset", status_o.in_reset, 1'b1);
    repeat (hold) begin
      check("hold_stall", status_o.in_boot | status_o.run, 1'b0);
      @(negedge mclk_i);
    end
    ext_hold = 1'b0;
    n = 0;
    lo = (c != CAUSE_NONE && hl) ? BL : BF;
    hi = lo + 3;
    while (status_o.run !== 1'b1 && n < 20000) begin
      @(negedge mclk_i);
      n++;
    end
    check("boot_len", (n >= lo && n <= hi), 1);
    check("first_fetch", status_o.first_fetch, 1'b1);
    check("left_reset", status_o.in_reset | status_o.in_boot, 1'b0);
    check("pin_released", pin_n, 1'b1);
    @(negedge mclk_i);
    check("fetch_pulse", status_o.first_fetch, 1'b0);
  endtask : run_seq

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    run_seq(CAUSE_NONE, 1'b0, 1'b0, 0);
    for (int i = 0; i < 5; i++) begin
      run_seq(cause_e'(3'(i % 4 + 1)), i[0], ~i[0], 0);
    end
    run_seq(CAUSE_FUNC_SHORT, 1'b0, 1'b1, 15);
    // a new cause mid-sequence restarts with the new length
    cause_i = CAUSE_FUNC_LONG;
    @(negedge mclk_i);
    cause_i = CAUSE_NONE;
    repeat (10) @(negedge mclk_i);
    run_seq(CAUSE_FUNC_SHORT, 1'b0, 1'b0, 0);
    for (int i = 0; i < 12; i++) begin
      run_seq(cause_e'(3'($unsigned($random(seed)) % 4 + 1)),
              1'($random(seed)), 1'($random(seed)),
              ($random(seed) & 1) ? 0 : $unsigned($random(seed)) % 20);
    end
    // second reset in mid-run
    rst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    check("pin_low_in_reset", pin_n, 1'b0);
    rst_i = 1'b0;
    run_seq(CAUSE_NONE, 1'b0, 1'b0, 0);
    results();
  end

  initial begin
    repeat (40000) @(posedge mclk_i);
    bad_count++;
    results();
  end
endmodule : reset_sequence_timing_tb_top

// ===== hw/reset_sequence_timing.sv
// Purpose: device reset sequencer driving the open-drain reset pin
// Assumes: inputs synchronous to mclk_i; one reset cause pulse at a time
// Notes: pin released only at end of reset phases; never driven high
`timescale 1ns/1ps

// How it works
// - destructive with self test: long hold
// - destructive without self test: short hold
// - external long sequence: own count
// - functional long sequence: own count
// - functional short sequence: own count
// - boot firmware 200 us, header first
// - boot firmware 320 us, header last
// - run mode starts with first fetch
// - device pulls reset pin low internally
// - device never drives pin high
// - pin released at end of phases
module reset_sequence_timing #(
  parameter int unsigned DSELF_CYCLES = rst_seq_pkg::DSELF_CYC,
  parameter int unsigned DPLAIN_CYCLES = rst_seq_pkg::DPLAIN_CYC,
  parameter int unsigned EXTLONG_CYCLES = rst_seq_pkg::EXTLONG_CYC,
  parameter int unsigned FLONG_CYCLES = rst_seq_pkg::FLONG_CYC,
  parameter int unsigned FSHORT_CYCLES = rst_seq_pkg::FSHORT_CYC,
  parameter int unsigned BOOT_FIRST_CYCLES = rst_seq_pkg::BOOT_FIRST_CYC,
  parameter int unsigned BOOT_LAST_CYCLES = rst_seq_pkg::BOOT_LAST_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire rst_seq_pkg::cause_e cause_i,
  input wire logic selftest_en_i,
  input wire logic header_last_i,
  input wire logic reset_pin_n_i,
  output logic reset_pin_n_o,
  output logic reset_pin_n_oe_n_o,
  output rst_seq_pkg::seq_status_s status_o
);
  import rst_seq_pkg::*;

  localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic last_boot_q;
  pin_drive_s pin_q;
  seq_status_s status_q;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = n[CNT_W-1:0];
  endfunction : cyc

  // ****************************************
  // sequence selection
  // ****************************************
  logic [CNT_W-1:0] seq_len;
  state_e start_st;
  always_comb begin
    seq_len = cyc(FSHORT_CYCLES);
    start_st = ST_RESET;
    unique case (cause_i)
      CAUSE_DESTRUCTIVE: begin
        if (selftest_en_i) begin
          seq_len = cyc(DSELF_CYCLES);
          start_st = ST_SELFTEST;
        end else begin
          seq_len = cyc(DPLAIN_CYCLES);
        end
      end
      CAUSE_EXT_LONG: seq_len = cyc(EXTLONG_CYCLES);
      CAUSE_FUNC_LONG: seq_len = cyc(FLONG_CYCLES);
      CAUSE_FUNC_SHORT: seq_len = cyc(FSHORT_CYCLES);
      default: start_st = ST_RUN;
    endcase
  end

  logic cause_hit;
  assign cause_hit = cause_i != CAUSE_NONE;

  // ****************************************
  // state and counter
  // ****************************************
  always_comb begin
    cnt_d = cnt_q - ONE;
    if (cause_hit) begin
      cnt_d = seq_len - ONE;
    end else if (state_q == ST_HOLD && reset_pin_n_i) begin
      cnt_d = cyc(last_boot_q ? BOOT_LAST_CYCLES : BOOT_FIRST_CYCLES) - ONE;
    end else if (cnt_q == '0) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      // power-on behaves like a destructive reset without self test
      state_q <= ST_RESET;
      cnt_q <= cyc(DPLAIN_CYCLES) - ONE;
      last_boot_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (cause_hit) begin
        state_q <= start_st;
        last_boot_q <= header_last_i;
      end else begin
        unique case (state_q)
          ST_SELFTEST, ST_RESET: begin
            if (cnt_q == '0) begin
              state_q <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            // external generator may keep the pin low past the phases
            if (reset_pin_n_i) begin
              state_q <= ST_BOOT;
            end
          end
          ST_BOOT: begin
            if (cnt_q == '0) begin
              state_q <= ST_RUN;
            end
          end
          ST_RUN: state_q <= ST_RUN;
          default: state_q <= ST_RESET;
        endcase
      end
    end
  end

  // ****************************************
  // reset pin drive
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_q <= '{out: 1'b0, oe_n: 1'b0};
    end else begin
      pin_q.out <= 1'b0;
      // drive low only during reset phases
      pin_q.oe_n <= ~(cause_hit ||
                      ((state_q == ST_SELFTEST || state_q == ST_RESET) &&
                       cnt_q != '0));
    end
  end
  assign reset_pin_n_o = pin_q.out;
  assign reset_pin_n_oe_n_o = pin_q.oe_n;

  // ****************************************
  // status
  // ****************************************
  logic boot_done;
  assign boot_done = state_q == ST_BOOT && cnt_q == '0;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else begin
      status_q.in_reset <= cause_hit || state_q == ST_SELFTEST ||
                           state_q == ST_RESET || state_q == ST_HOLD;
      status_q.in_boot <= !cause_hit && state_q == ST_BOOT && !boot_done;
      // run rises with the fetch pulse, not one cycle after it
      status_q.run <= !cause_hit && (state_q == ST_RUN || boot_done);
      // one-cycle pulse when run mode is entered
      status_q.first_fetch <= !cause_hit && boot_done;
    end
  end
  assign status_o = status_q;

  // ****************************************
  // checks
  // ****************************************
  logic [CNT_W-1:0] low_cnt_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i || pin_q.oe_n) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != '1) begin
      low_cnt_q <= low_cnt_q + ONE;
    end
  end

  property p_never_high;
    @(posedge mclk_i) disable iff (rst_i) !pin_q.oe_n |-> !pin_q.out;
  endproperty
  a_never_high: assert property (p_never_high)
    else $error("reset pin driven high");

  property p_self_len;
    @(posedge mclk_i) disable iff (rst_i)
      (cause_i == CAUSE_DESTRUCTIVE && selftest_en_i) |=>
        state_q == ST_SELFTEST && cnt_q == cyc(DSELF_CYCLES) - ONE;
  endproperty
  a_self_len: assert property (p_self_len)
    else $error("self test sequence length wrong");

  property p_plain_len;
    @(posedge mclk_i) disable iff (rst_i)
      (cause_i == CAUSE_DESTRUCTIVE && !selftest_en_i) |=>
        state_q == ST_RESET && cnt_q == cyc(DPLAIN_CYCLES) - ONE;
  endproperty
  a_plain_len: assert property (p_plain_len)
    else $error("plain destructive length wrong");

  property p_ext_len;
    @(posedge mclk_i) disable iff (rst_i)
      cause_i == CAUSE_EXT_LONG |=> cnt_q == cyc(EXTLONG_CYCLES) - ONE;
  endproperty
  a_ext_len: assert property (p_ext_len)
    else $error("external long length wrong");

  property p_flong_len;
    @(posedge mclk_i) disable iff (rst_i)
      cause_i == CAUSE_FUNC_LONG |=> cnt_q == cyc(FLONG_CYCLES) - ONE;
  endproperty
  a_flong_len: assert property (p_flong_len)
    else $error("functional long length wrong");

  property p_short_len;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(pin_q.oe_n) |-> low_cnt_q >= cyc(FSHORT_CYCLES);
  endproperty
  a_short_len: assert property (p_short_len)
    else $error("pin released too early");

  property p_boot_first;
    @(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_HOLD && reset_pin_n_i && !cause_hit && !last_boot_q)
        |=> cnt_q == cyc(BOOT_FIRST_CYCLES) - ONE;
  endproperty
  a_boot_first: assert property (p_boot_first)
    else $error("boot time first header wrong");

  property p_boot_last;
    @(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_HOLD && reset_pin_n_i && !cause_hit && last_boot_q)
        |=> cnt_q == cyc(BOOT_LAST_CYCLES) - ONE;
  endproperty
  a_boot_last: assert property (p_boot_last)
    else $error("boot time last header wrong");

  property p_fetch;
    @(posedge mclk_i) disable iff (rst_i)
      status_q.first_fetch |-> status_q.run ##1 !status_q.first_fetch;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("first fetch not at run entry");

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_HOLD && !reset_pin_n_i && !cause_hit) |=>
        state_q == ST_HOLD;
  endproperty
  a_hold: assert property (p_hold)
    else $error("left hold while pin low");

  property p_drive;
    @(posedge mclk_i) disable iff (rst_i)
      cause_hit |=> !pin_q.oe_n;
  endproperty
  a_drive: assert property (p_drive)
    else $error("pin not pulled low on reset");

  // the pin is let go only once the phase count has run out
  property p_release;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(pin_q.oe_n) |-> state_q == ST_HOLD;
  endproperty
  a_release: assert property (p_release)
    else $error("pin released outside hold");

  property p_no_drive_after;
    @(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_BOOT || state_q == ST_RUN) |-> pin_q.oe_n;
  endproperty
  a_no_drive_after: assert property (p_no_drive_after)
    else $error("pin still pulled low after phases");

  property p_status_excl;
    @(posedge mclk_i) disable iff (rst_i)
      $onehot0({status_q.in_reset, status_q.in_boot, status_q.run});
  endproperty
  a_status_excl: assert property (p_status_excl)
    else $error("status flags overlap");

  property p_run_stay;
    @(posedge mclk_i) disable iff (rst_i)
      (status_q.run && !cause_hit) |=> status_q.run;
  endproperty
  a_run_stay: assert property (p_run_stay)
    else $error("run mode left without a cause");

  c_selftest: cover property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_SELFTEST ##1 state_q == ST_HOLD);
  c_extend: cover property (@(posedge mclk_i) disable iff (rst_i)
    state_q == ST_HOLD ##1 state_q == ST_HOLD);
  c_run: cover property (@(posedge mclk_i) disable iff (rst_i)
    status_q.first_fetch);
  c_short: cover property (@(posedge mclk_i) disable iff (rst_i)
    cause_i == CAUSE_FUNC_SHORT);
  c_boot_last: cover property (@(posedge mclk_i) disable iff (rst_i)
    boot_done && last_boot_q);

endmodule : reset_sequence_timing

// ===== hw/rst_seq_pkg.sv
// Purpose: constants and types for the device reset sequencer
// Assumes: 40 MHz clock (25 ns period)
// Notes: durations kept in nanoseconds, cycle counts derived from them
package rst_seq_pkg;

  // ****************************************
  // clock and durations
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  // least durations, ns
  localparam int unsigned DESTRUCTIVE_SELFTEST_DURATION_NS = 5730000;
  localparam int unsigned DESTRUCTIVE_PLAIN_DURATION_NS = 111000;
  localparam int unsigned EXTERNAL_LONG_DURATION_NS = 5729000;
  localparam int unsigned FUNCTIONAL_LONG_DURATION_NS = 110000;
  localparam int unsigned FUNCTIONAL_SHORT_DURATION_NS = 7000;
  // typical durations, ns
  localparam int unsigned DESTRUCTIVE_SELFTEST_TYP_NS = 7796000;
  localparam int unsigned DESTRUCTIVE_PLAIN_TYP_NS = 182000;
  localparam int unsigned EXTERNAL_LONG_TYP_NS = 7793000;
  localparam int unsigned FUNCTIONAL_LONG_TYP_NS = 179000;
  localparam int unsigned FUNCTIONAL_SHORT_TYP_NS = 9000;
  // boot firmware, typical, ns
  localparam int unsigned BOOT_FIRST_NS = 200000;
  localparam int unsigned BOOT_LAST_NS = 320000;

  // least times round up
  localparam int unsigned DSELF_CYC =
    (DESTRUCTIVE_SELFTEST_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DPLAIN_CYC =
    (DESTRUCTIVE_PLAIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXTLONG_CYC =
    (EXTERNAL_LONG_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLONG_CYC =
    (FUNCTIONAL_LONG_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FSHORT_CYC =
    (FUNCTIONAL_SHORT_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BOOT_FIRST_CYC = BOOT_FIRST_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOT_LAST_CYC = BOOT_LAST_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 18;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_DESTRUCTIVE = 3'h1,
    CAUSE_EXT_LONG = 3'h2,
    CAUSE_FUNC_LONG = 3'h3,
    CAUSE_FUNC_SHORT = 3'h4
  } cause_e;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_SELFTEST = 3'b001,
    ST_RESET = 3'b010,
    ST_HOLD = 3'b011,
    ST_BOOT = 3'b100
  } state_e;

  // open-drain reset pin, oe low means driving
  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_s;

  typedef struct packed {
    logic in_reset;
    logic in_boot;
    logic run;
    logic first_fetch;
  } seq_status_s;

endpackage : rst_seq_pkg
